// >>> pkg/sppr_consts.svh
// Overview of operation
// - Character is start bit, seven data bits, parity bit, one or more stop bits.
// - Assemble data plus parity into eight bits, check parity, hand over in parallel.
// - Start bit leading edge starts bit timing that shifts bits into a register.
// - Start-of-message code 001 clears receive logic and the latched parity error.
// - Failed parity replaces the character with octal 100 before transfer.
// - End-of-message with no latched error raises reverse channel until printer ready.
// - End-of-message after an error leaves reverse channel alone; error held till next start.
// - Reverse channel stays up at least 200 ms and while printer is busy.
// - After reverse channel drops, end-of-message is ignored another 200 ms.
// - Printer busy alone never raises reverse channel, only prolongs it.
// - Serial rate 110 to 9600 baud set by summing power-of-two intervals.
// - Bit timing reference 0.2 MHz below 600 baud, 1 MHz at 600 and above.
// - Parity even, odd or off; off suppresses marker; marker-only mode always marks.
// - Option chooses whether printer busy affects reverse channel.
// - Option chooses whether buffer high count gates reverse channel.
// - Terminal-ready output: printer selected, always on, or busy of either polarity.
// - Start bit needs the line in space for at least half a bit.
// - Start detection only while modem ready and carrier present.
// - Decode pulses at twice baud, every other one samples mid-bit.
// - Shift register preset to all ones after each transfer.
`ifndef SPPR_CONSTS_SVH
`define SPPR_CONSTS_SVH
`define SPPR_CLK_HZ 100000000
`define SPPR_GUARD_MS 200
`define SPPR_GUARD_CYC (`SPPR_CLK_HZ / 1000 * `SPPR_GUARD_MS)
`define SPPR_OSC_LO_HZ 200000
`define SPPR_OSC_HI_HZ 1000000
`define SPPR_SOM_CODE 7'h01
`define SPPR_EOM_CODE 7'h03
`define SPPR_ERR_CHAR 7'h40
`define SPPR_ALL_ONES 8'hFF
`define SPPR_HALF_UNITS 10'h0DB
`define SPPR_NBITS 4'h9
`define SPPR_MODE_EVEN 3'h0
`define SPPR_MODE_ODD 3'h1
`define SPPR_MODE_OFF 3'h2
`define SPPR_MODE_EVEN_AT 3'h3
`define SPPR_MODE_ODD_AT 3'h4
`define SPPR_DTR_SEL 2'h0
`define SPPR_DTR_ON 2'h1
`define SPPR_DTR_BUSY 2'h2
`define SPPR_DTR_BUSY_N 2'h3
`define SPPR_ADR_CTRL 4'h0
`define SPPR_ADR_STAT 4'h4
`define SPPR_ADR_DATA 4'h8
`endif

// >>> pkg/sppr_pkg.sv
package sppr_pkg;
  typedef enum logic [1:0] {SPPR_IDLE, SPPR_START, SPPR_BITS, SPPR_DONE} sppr_rx_t;
  typedef enum logic [1:0] {SPPR_RC_OFF, SPPR_RC_ON, SPPR_RC_GUARD} sppr_rc_t;
  typedef struct packed {
    logic [9:0] half_units;
    logic osc_hi;
    logic [1:0] dtr_mode;
    logic high_count_input_en;
    logic busy_en;
    logic [2:0] par_mode;
  } sppr_cfg_t;
  typedef struct packed {
    logic [7:0] data;
    logic err;
  } sppr_char_t;
endpackage

// >>> hw/sppr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sppr_consts.svh"
module sppr_top import sppr_pkg::*; #(
  parameter int GUARD_CYC = `SPPR_GUARD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_data_i,
  input wire logic modem_ready_n_i,
  input wire logic carrier_present_n_i,
  input wire logic prn_busy_i,
  input wire logic prn_select_i,
  input wire logic high_count_input_i,
  output logic [7:0] prn_data_o,
  output logic prn_strobe_o,
  output logic reverse_channel_o,
  output logic term_ready_o
);
  localparam int OSC_LO_DIV = `SPPR_CLK_HZ / `SPPR_OSC_LO_HZ;
  localparam int OSC_HI_DIV = `SPPR_CLK_HZ / `SPPR_OSC_HI_HZ;

  // Two-flop synchronisers; stage one is read only by stage two
  logic [5:0] s1_reg, s2_reg;
  always_ff @(posedge clk_i) begin
    s1_reg <= {rx_data_i, modem_ready_n_i, carrier_present_n_i, prn_busy_i,
      high_count_input_i, prn_select_i};
    s2_reg <= s1_reg;
  end
  logic rxd, rdy_n, car_n, busy, high_count_input, prn_sel;
  assign {rxd, rdy_n, car_n, busy, high_count_input, prn_sel} = s2_reg;

  // Configuration register
  sppr_cfg_t cfg_reg, cfg_next;
  logic [31:0] rd_reg, rd_next;
  logic ack_reg, ack_next;
  sppr_char_t last_reg, last_next;

  // Oscillator tick from the system clock
  logic [8:0] osc_cnt_reg, osc_cnt_next;
  logic osc_tick;
  always_comb begin
    osc_tick = 1'b0;
    osc_cnt_next = osc_cnt_reg + 9'h001;
    // Compare high side so a shorter divide after a rate change wraps at once
    if (osc_cnt_reg >= 9'((cfg_reg.osc_hi ? OSC_HI_DIV : OSC_LO_DIV) - 1)) begin
      osc_cnt_next = 9'h000;
      osc_tick = 1'b1;
    end
  end

  // Receiver
  sppr_rx_t st_reg, st_next;
  logic [9:0] bc_reg, bc_next;
  logic odd_reg, odd_next;
  logic [3:0] nb_reg, nb_next;
  logic [7:0] sh_reg, sh_next;
  logic par_reg, par_next;
  logic perr_reg, perr_next;
  logic [7:0] pd_reg, pd_next;
  logic ps_reg, ps_next;
  logic som_hit, eom_hit;
  logic bad;
  always_comb begin
    st_next = st_reg;
    bc_next = bc_reg;
    odd_next = odd_reg;
    nb_next = nb_reg;
    sh_next = sh_reg;
    par_next = par_reg;
    perr_next = perr_reg;
    pd_next = pd_reg;
    ps_next = 1'b0;
    som_hit = 1'b0;
    eom_hit = 1'b0;
    bad = 1'b0;
    case (st_reg)
      SPPR_IDLE: begin
        bc_next = 10'h000;
        odd_next = 1'b0;
        nb_next = 4'h0;
        if (!rxd && !rdy_n && !car_n) begin
          st_next = SPPR_START;
        end
      end
      SPPR_START, SPPR_BITS: begin
        if (st_reg == SPPR_START && rxd) begin
          st_next = SPPR_IDLE;
        end else if (osc_tick) begin
          // Half-bit decode; every other decode samples
          if (bc_reg == cfg_reg.half_units - 10'h001) begin
            bc_next = 10'h000;
            odd_next = !odd_reg;
            if (!odd_reg) begin
              st_next = SPPR_BITS;
              nb_next = nb_reg + 4'h1;
              if (nb_reg != 4'h0) begin
                sh_next = {rxd, sh_reg[7:1]};
                par_next = par_reg ^ rxd;
              end
              if (nb_reg == `SPPR_NBITS - 4'h1) begin
                st_next = SPPR_DONE;
              end
            end
          end else begin
            bc_next = bc_reg + 10'h001;
          end
        end
      end
      SPPR_DONE: begin
        // A low parity bit keeps us here; only the entry cycle may transfer
        if (odd_reg) begin
          odd_next = 1'b0;
          case (cfg_reg.par_mode)
            `SPPR_MODE_EVEN, `SPPR_MODE_EVEN_AT: bad = par_reg;
            `SPPR_MODE_ODD, `SPPR_MODE_ODD_AT: bad = !par_reg;
            default: bad = 1'b0;
          endcase
          som_hit = sh_reg[6:0] == `SPPR_SOM_CODE;
          eom_hit = sh_reg[6:0] == `SPPR_EOM_CODE && !bad;
          if (som_hit) begin
            perr_next = 1'b0;
          end
          if (bad && cfg_reg.par_mode <= `SPPR_MODE_ODD) begin
            perr_next = 1'b1;
          end
          if (cfg_reg.par_mode >= `SPPR_MODE_EVEN_AT) begin
            pd_next = {1'b0, `SPPR_ERR_CHAR};
          end else if (bad) begin
            pd_next = {1'b0, `SPPR_ERR_CHAR};
          end else begin
            pd_next = sh_reg;
          end
          ps_next = 1'b1;
          sh_next = `SPPR_ALL_ONES;
          par_next = 1'b0;
        end
        if (rxd) begin
          st_next = SPPR_IDLE;
        end
      end
      default: st_next = SPPR_IDLE;
    endcase
  end

  // Reverse channel with 200 ms minimum and guard
  sppr_rc_t rc_reg, rc_next;
  logic [31:0] gt_reg, gt_next;
  logic rc_out_next;
  always_comb begin
    rc_next = rc_reg;
    gt_next = gt_reg;
    case (rc_reg)
      SPPR_RC_OFF: begin
        gt_next = 32'h0;
        if (eom_hit && !perr_reg && !(cfg_reg.high_count_input_en && high_count_input)) begin
          rc_next = SPPR_RC_ON;
        end
      end
      SPPR_RC_ON: begin
        if (gt_reg < 32'(GUARD_CYC - 1)) begin
          gt_next = gt_reg + 32'h1;
        end else if (!(cfg_reg.busy_en && busy) && !(cfg_reg.high_count_input_en && high_count_input)) begin
          rc_next = SPPR_RC_GUARD;
          gt_next = 32'h0;
        end
      end
      SPPR_RC_GUARD: begin
        gt_next = gt_reg + 32'h1;
        if (gt_reg == 32'(GUARD_CYC - 1)) begin
          rc_next = SPPR_RC_OFF;
        end
      end
      default: rc_next = SPPR_RC_OFF;
    endcase
    rc_out_next = rc_next == SPPR_RC_ON;
  end

  // Terminal ready
  logic dtr_next;
  always_comb begin
    case (cfg_reg.dtr_mode)
      `SPPR_DTR_SEL: dtr_next = prn_sel;
      `SPPR_DTR_ON: dtr_next = 1'b1;
      `SPPR_DTR_BUSY: dtr_next = busy;
      default: dtr_next = !busy;
    endcase
  end

  // Wishbone slave, one wait state, ack drops the cycle after
  always_comb begin
    cfg_next = cfg_reg;
    last_next = last_reg;
    if (ps_reg) begin
      last_next = '{data: pd_reg, err: perr_reg};
    end
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    rd_next = 32'h0;
    if (ack_next) begin
      case (wb_adr_i)
        `SPPR_ADR_CTRL: begin
          rd_next = {14'h0, cfg_reg};
          if (wb_we_i && wb_sel_i[0]) begin
            cfg_next = 18'({cfg_reg[17:8], wb_dat_i[7:0]});
          end
          if (wb_we_i && wb_sel_i[1]) begin
            cfg_next[17:8] = {cfg_next[17:16], wb_dat_i[15:8]};
          end
          if (wb_we_i && wb_sel_i[2]) begin
            cfg_next[17:16] = wb_dat_i[17:16];
          end
        end
        `SPPR_ADR_STAT: rd_next = {26'h0, rc_reg, perr_reg, st_reg, reverse_channel_o};
        `SPPR_ADR_DATA: rd_next = {23'h0, last_reg};
        default: rd_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_reg <= 9'h000;
      st_reg <= SPPR_IDLE;
      bc_reg <= 10'h000;
      odd_reg <= 1'b0;
      nb_reg <= 4'h0;
      sh_reg <= `SPPR_ALL_ONES;
      par_reg <= 1'b0;
      perr_reg <= 1'b0;
      pd_reg <= 8'h00;
      ps_reg <= 1'b0;
      rc_reg <= SPPR_RC_OFF;
      gt_reg <= 32'h0;
      reverse_channel_o <= 1'b0;
      term_ready_o <= 1'b0;
      cfg_reg <= '{par_mode: `SPPR_MODE_EVEN, busy_en: 1'b1, high_count_input_en: 1'b0,
        dtr_mode: `SPPR_DTR_SEL, osc_hi: 1'b1, half_units: `SPPR_HALF_UNITS};
      last_reg <= '0;
      rd_reg <= 32'h0;
      ack_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      st_reg <= st_next;
      bc_reg <= bc_next;
      odd_reg <= odd_next;
      nb_reg <= nb_next;
      sh_reg <= sh_next;
      par_reg <= par_next;
      perr_reg <= perr_next;
      pd_reg <= pd_next;
      ps_reg <= ps_next;
      rc_reg <= rc_next;
      gt_reg <= gt_next;
      reverse_channel_o <= rc_out_next;
      term_ready_o <= dtr_next;
      cfg_reg <= cfg_next;
      last_reg <= last_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
    end
  end
  assign prn_data_o = pd_reg;
  assign prn_strobe_o = ps_reg;
  assign wb_dat_o = rd_reg;
  assign wb_ack_o = ack_reg;

  // Hold count so the minimum-width check can see it
  logic [31:0] on_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !reverse_channel_o) begin
      on_cnt <= 32'h0;
    end else begin
      on_cnt <= on_cnt + 32'h1;
    end
  end

  a_rc_min_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(reverse_channel_o) |-> $past(on_cnt) >= 32'(GUARD_CYC - 1))
    else $error("reverse channel too short");
  a_busy_no_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(reverse_channel_o) |-> $past(eom_hit))
    else $error("reverse channel raised without end code");
  a_err_blocks_rc: assert property (@(posedge clk_i) disable iff (rst_i)
    (rc_reg == SPPR_RC_OFF && perr_reg) |=> !reverse_channel_o)
    else $error("reverse channel raised after parity error");
  a_guard_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    rc_reg == SPPR_RC_GUARD |=> !reverse_channel_o)
    else $error("reverse channel during guard");
  a_som_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (som_hit && !bad) |=> !perr_reg)
    else $error("start code did not clear error");
  a_err_marker: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == SPPR_DONE && bad) |=> prn_strobe_o && prn_data_o == {1'b0, `SPPR_ERR_CHAR})
    else $error("marker not substituted");
  a_preset_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    prn_strobe_o |-> sh_reg == `SPPR_ALL_ONES)
    else $error("shift register not preset");
  a_start_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == SPPR_IDLE && (rdy_n || car_n)) |=> st_reg == SPPR_IDLE)
    else $error("start accepted without modem ready");
endmodule
`default_nettype wire

// >>> bench/sppr_modem.sv
`timescale 1ns/1ps
`default_nettype none
module sppr_modem #(
  parameter int BIT_CYC = 200
) (
  input wire logic clk_i,
  output logic tx_o
);
  // Idle line rests at mark
  initial begin
    tx_o = 1'b1;
  end
  // Start, seven data bits LSB first, parity, two stop bits
  task automatic send(input logic [7:0] c);
    logic [10:0] frame;
    frame = {2'b11, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i);
      tx_o <= frame[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_serial_to_parallel_print_receiver.sv
`timescale 1ns/1ps
`default_nettype none
`include "sppr_consts.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_serial_to_parallel_print_receiver;
  // Short guard keeps the run small; half bit of one 1 MHz tick gives 200 clocks a bit
  localparam int GUARD = 3000;
  localparam logic [3:0] DTR_EXP = 4'b0110;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, rx, busy, sel, rdy_n, car_n, hc;
  logic prn_strobe_o, reverse_channel_o, term_ready_o;
  logic [3:0] wb_adr;
  logic [31:0] wb_dat, wb_dat_o, q;
  logic [7:0] prn_data_o, got;
  int mismatches, samples_checked, n_stb, rc_len, last_len;
  sppr_top #(.GUARD_CYC(GUARD)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_data_i(rx), .modem_ready_n_i(rdy_n),
    .carrier_present_n_i(car_n), .prn_busy_i(busy), .prn_select_i(sel),
    .high_count_input_i(hc), .prn_data_o(prn_data_o), .prn_strobe_o(prn_strobe_o),
    .reverse_channel_o(reverse_channel_o), .term_ready_o(term_ready_o));
  sppr_modem #(.BIT_CYC(200)) u_modem (.clk_i(clk_i), .tx_o(rx));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (prn_strobe_o === 1'b1) begin
      got <= prn_data_o;
      n_stb <= n_stb + 1;
    end
    if (reverse_channel_o === 1'b1) rc_len <= rc_len + 1;
    else if (rc_len != 0) begin
      last_len <= rc_len;
      rc_len <= 0;
    end
  end
  function automatic logic [7:0] odd_ch(input logic [6:0] d);
    return {~^d, d};
  endfunction
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no bus acknowledge", $time);
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ch(input logic [7:0] c, input logic [7:0] want);
    int n0;
    n0 = n_stb;
    u_modem.send(c);
    `CHK(got, want)
    `CHK(n_stb, n0 + 1)
  endtask
  task automatic wait_rc(input logic v);
    int n;
    n = 0;
    while (reverse_channel_o !== v && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (reverse_channel_o !== v) begin
      mismatches++;
      $display("unexpected at %0t: reverse channel wait timed out", $time);
    end
    @(posedge clk_i);
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    // Tests need about 55k cycles; give up at 90k
    #900000;
    mismatches++;
    print_verdict;
  end
  initial begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, busy, sel, rdy_n, car_n, hc} = '0;
    wb_adr = 4'h0;
    wb_dat = 32'h0;
    {mismatches, samples_checked, n_stb, rc_len, last_len} = '0;
    got = 8'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, `SPPR_ADR_CTRL, 32'h0);
    `CHK(q, 32'h0000DB88)
    `CHK(reverse_channel_o, 1'b0)
    wb(1'b0, 4'hC, 32'h0);
    `CHK(q, 32'h00000000)
    wb(1'b1, `SPPR_ADR_CTRL, 32'h000001A9);
    car_n <= 1'b1;
    u_modem.send(odd_ch(7'h41));
    `CHK(n_stb, 0)
    car_n <= 1'b0;
    ch(odd_ch(`SPPR_SOM_CODE), odd_ch(`SPPR_SOM_CODE));
    ch(odd_ch(7'h48), odd_ch(7'h48));
    ch(odd_ch(`SPPR_EOM_CODE), odd_ch(`SPPR_EOM_CODE));
    `CHK(reverse_channel_o, 1'b1)
    busy <= 1'b1;
    repeat (4000) @(posedge clk_i);
    `CHK(reverse_channel_o, 1'b1)
    busy <= 1'b0;
    wait_rc(1'b0);
    // End code sent too early on purpose; the guard must swallow it
    ch(odd_ch(`SPPR_EOM_CODE), odd_ch(`SPPR_EOM_CODE));
    `CHK(reverse_channel_o, 1'b0)
    `CHK(last_len > 4000, 1'b1)
    busy <= 1'b1;
    repeat (3000) @(posedge clk_i);
    `CHK(reverse_channel_o, 1'b0)
    busy <= 1'b0;
    ch(odd_ch(7'h48) ^ 8'h80, {1'b0, `SPPR_ERR_CHAR});
    wb(1'b0, `SPPR_ADR_DATA, 32'h0);
    `CHK(q, 32'h00000081)
    ch(odd_ch(`SPPR_EOM_CODE), odd_ch(`SPPR_EOM_CODE));
    `CHK(reverse_channel_o, 1'b0)
    wb(1'b0, `SPPR_ADR_STAT, 32'h0);
    `CHK(q, 32'h00000008)
    ch(odd_ch(`SPPR_SOM_CODE), odd_ch(`SPPR_SOM_CODE));
    ch(odd_ch(`SPPR_EOM_CODE), odd_ch(`SPPR_EOM_CODE));
    `CHK(reverse_channel_o, 1'b1)
    wait_rc(1'b0);
    `CHK(last_len >= GUARD, 1'b1)
    repeat (GUARD) @(posedge clk_i);
    wb(1'b1, `SPPR_ADR_CTRL, 32'h000001AA);
    ch(odd_ch(7'h55) ^ 8'h80, odd_ch(7'h55) ^ 8'h80);
    wb(1'b1, `SPPR_ADR_CTRL, 32'h000001AC);
    ch(odd_ch(7'h55), 8'h40);
    wb(1'b1, `SPPR_ADR_CTRL, 32'h000001A8);
    ch(8'h55, 8'h55);
    // Buffer attached: busy ignored, high count gates and prolongs the channel
    wb(1'b1, `SPPR_ADR_CTRL, 32'h00000190);
    busy <= 1'b1;
    hc <= 1'b1;
    ch(odd_ch(`SPPR_SOM_CODE) ^ 8'h80, odd_ch(`SPPR_SOM_CODE) ^ 8'h80);
    ch(odd_ch(7'h0E) ^ 8'h80, odd_ch(7'h0E) ^ 8'h80);
    ch(odd_ch(`SPPR_EOM_CODE) ^ 8'h80, odd_ch(`SPPR_EOM_CODE) ^ 8'h80);
    `CHK(reverse_channel_o, 1'b0)
    hc <= 1'b0;
    ch(odd_ch(`SPPR_EOM_CODE) ^ 8'h80, odd_ch(`SPPR_EOM_CODE) ^ 8'h80);
    `CHK(reverse_channel_o, 1'b1)
    hc <= 1'b1;
    repeat (4000) @(posedge clk_i);
    `CHK(reverse_channel_o, 1'b1)
    hc <= 1'b0;
    wait_rc(1'b0);
    `CHK(reverse_channel_o, 1'b0)
    busy <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, `SPPR_ADR_CTRL, 32'h00000188 | (m << 5));
      repeat (2) @(posedge clk_i);
      `CHK(term_ready_o, DTR_EXP[m])
    end
    print_verdict;
  end
endmodule
`default_nettype wire
